// File: rtl/uep_regs.vh
`ifndef UEP_REGS_VH
`define UEP_REGS_VH

// ----------------------------------------------------------------
// Register offsets in the special function register space
// ----------------------------------------------------------------
`define UEP_PHY_CTRL_OFF 8'hd1
`define UEP_EP1_CTRL_OFF 8'hd2
`define UEP_EP1_TLEN_OFF 8'hd3
`define UEP_EP2_CTRL_OFF 8'hd4
`define UEP_EP2_TLEN_OFF 8'hd5
`define UEP_EP3_CTRL_OFF 8'hd6
`define UEP_EP3_TLEN_OFF 8'hd7
`define UEP_EP0_CTRL_OFF 8'hdc
`define UEP_EP0_TLEN_OFF 8'hdd
`define UEP_EP4_CTRL_OFF 8'hde
`define UEP_EP4_TLEN_OFF 8'hdf
`define UEP_EP2_BUF_LO_OFF 8'he4
`define UEP_EP2_BUF_HI_OFF 8'he5
`define UEP_EP3_BUF_LO_OFF 8'he6
`define UEP_EP3_BUF_HI_OFF 8'he7
`define UEP_MODE14_OFF 8'hea
`define UEP_MODE23_OFF 8'heb
`define UEP_EP0_BUF_LO_OFF 8'hec
`define UEP_EP0_BUF_HI_OFF 8'hed
`define UEP_EP1_BUF_LO_OFF 8'hee
`define UEP_EP1_BUF_HI_OFF 8'hef
`define UEP_EVT_FLAG_OFF 8'hd8
`define UEP_EVT_STAT_OFF 8'hd9
`define UEP_RX_LEN_OFF 8'hdb
`define UEP_USB_CTRL_OFF 8'he2

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define UEP_PHY_PD_DIS 7
`define UEP_PHY_DP_LVL 5
`define UEP_PHY_DM_LVL 4
`define UEP_PHY_LOW_SPD 2
`define UEP_PHY_USER 1
`define UEP_PHY_PORT_EN 0
`define UEP_CTL_RX_TOG 7
`define UEP_CTL_TX_TOG 6
`define UEP_CTL_AUTO 4
`define UEP_USB_PULLUP 5
`define UEP_USB_SOFT_RST 2
`define UEP_FLG_BUS_RST 0
`define UEP_FLG_XFER 1
`define UEP_FLG_SUSP 2
`define UEP_STAT_TOG_OK 6

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define UEP_PHY_CTRL_RST 8'h80
`define UEP_USB_CTRL_RST 8'h04
`define UEP_CTL_RST 8'h00
`define UEP_TLEN_RST 8'h00
`define UEP_MODE_RST 8'h00

// ----------------------------------------------------------------
// Sizes, encodings and counts
// ----------------------------------------------------------------
`define UEP_MAX_PKT 7'h40
`define UEP_RAM_AW 10
`define UEP_RES_ACK 2'b00
`define UEP_RES_NONE 2'b01
`define UEP_RES_NAK 2'b10
`define UEP_RES_STALL 2'b11
`define UEP_PID_OUT 2'b00
`define UEP_PID_IN 2'b10
`define UEP_PID_SETUP 2'b11

`endif

// File: rtl/uep_ram.v
`timescale 1ns/100ps
`include "uep_regs.vh"

// ----------------------------------------------------------------
// Buffer RAM, engine port and processor port
// ----------------------------------------------------------------
module uep_ram
(
  input wire core_clk,
  input wire [`UEP_RAM_AW-1:0] eng_addr,
  input wire eng_we,
  input wire [7:0] eng_wdata,
  output reg [7:0] eng_rdata,
  input wire [`UEP_RAM_AW-1:0] cpu_addr,
  input wire cpu_we,
  input wire [7:0] cpu_wdata,
  output reg [7:0] cpu_rdata
);

  reg [7:0] mem [0:(1<<`UEP_RAM_AW)-1];

  // Both ports in one process so the array has a single driver;
  // on a same-address write collision the processor byte wins
  always @(posedge core_clk)
  begin
    if (eng_we)
      mem[eng_addr] <= eng_wdata;
    if (cpu_we)
      mem[cpu_addr] <= cpu_wdata;
    eng_rdata <= mem[eng_addr];
    cpu_rdata <= mem[cpu_addr];
  end

endmodule

// File: rtl/uep_ep_ctl.v
`timescale 1ns/100ps
`include "uep_regs.vh"

// ----------------------------------------------------------------
// One endpoint: control register and transmit length register
// ----------------------------------------------------------------
module uep_ep_ctl
#(
  parameter HAS_AUTO = 1
)
(
  input wire core_clk,
  input wire rst_b,
  input wire sie_clr,
  input wire wr_ctl,
  input wire wr_len,
  input wire [7:0] wdata,
  input wire rx_done,
  input wire tx_done,
  output wire [7:0] ctl_q,
  output wire [7:0] len_q
);

  reg [7:0] ctl_r;
  reg [7:0] len_r;
  wire auto_on;

  assign auto_on = (HAS_AUTO != 0) && ctl_r[`UEP_CTL_AUTO];
  assign ctl_q = ctl_r;
  assign len_q = len_r;

  // Software write wins over an automatic flip in the same cycle
  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctl_r <= `UEP_CTL_RST;
      len_r <= `UEP_TLEN_RST;
    end
    else if (sie_clr)
    begin
      ctl_r <= `UEP_CTL_RST;
      len_r <= `UEP_TLEN_RST;
    end
    else
    begin
      if (wr_ctl)
        ctl_r <= {wdata[7:6], 1'b0, (HAS_AUTO != 0) & wdata[4], wdata[3:0]};
      else
      begin
        if (auto_on && rx_done)
          ctl_r[`UEP_CTL_RX_TOG] <= ~ctl_r[`UEP_CTL_RX_TOG];
        if (auto_on && tx_done)
          ctl_r[`UEP_CTL_TX_TOG] <= ~ctl_r[`UEP_CTL_TX_TOG];
      end
      if (wr_len)
        len_r <= wdata;
    end
  end

endmodule

// File: rtl/uep_top.v
`timescale 1ns/100ps
`include "uep_regs.vh"

// Function
// - Five bidirectional endpoints 0..4; packets limited to 64 bytes.
// - Endpoint 0 is control endpoint sharing one 64-byte buffer for IN and OUT.
// - Endpoints 1-3 have separate IN/OUT buffers, single or double 64 bytes.
// - Endpoint 4 has separate single 64-byte IN and OUT buffers.
// - Each endpoint owns a control register and a transmit length register.
// - Pull-up enable attaches D+ (full) or D- (low) pull-up, enables device.
// - Bus reset, suspend/wake and transfer done set flags and request interrupt.
// - On transfer done, status shows endpoint number and token PID.
// - Received data toggle compared against expected OUT toggle; mismatch data still kept, status toggle-OK bit cleared.
// - Auto-toggle enable flips the toggle after each successful transfer.
// - IN data comes from own buffer with own transmit length.
// - OUT data lands in own buffer; count goes to shared receive length.
// - Buffer start is low/high byte pair; high byte keeps two bits.
// - Endpoints 0 and 4 share one start address; 1-3 each own one.
// - Pull-down disable bit: one off, zero on, reset one, independent of pins.
// - Two read-only bits show live D+ and D- levels.
// - Speed bit: one low speed, zero full speed, reset zero.
// - One general purpose bit with no hardware effect, reset zero.
// - Port enable bit enables physical port, reset zero.
// - Port control resets to pull-down disable set, others cleared.
// - OUT response: 00 ACK, 01 no handshake, 10 NAK, 11 STALL.
// - IN response: 00 data then ACK, 01 data no handshake, 10 NAK, 11 STALL.
// - Toggle bit zero means DATA0, one means DATA1.
// - Auto toggle exists only on endpoints 1 to 3.
module uep_top
(
  input wire core_clk,
  input wire rst_b,
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [7:0] sfr_wdata,
  output reg [7:0] sfr_rdata,
  input wire [`UEP_RAM_AW-1:0] xram_addr,
  input wire xram_we,
  input wire [7:0] xram_wdata,
  output wire [7:0] xram_rdata,
  input wire dplus_in,
  input wire dminus_in,
  output wire pullup_dp_en,
  output wire pullup_dm_en,
  output wire pulldown_en,
  output wire phy_enable,
  output wire phy_low_speed,
  output wire device_enable,
  input wire bus_reset_det,
  input wire suspend_det,
  input wire tok_stb,
  input wire [1:0] tok_pid,
  input wire [3:0] tok_ep,
  input wire rx_pid_stb,
  input wire rx_pid_data1,
  input wire rx_stb,
  input wire [7:0] rx_byte,
  input wire rx_end,
  input wire rx_err,
  input wire xfer_abort,
  output reg tx_start,
  output reg tx_data1,
  output wire tx_valid,
  output wire [7:0] tx_byte,
  input wire tx_ready,
  output reg tx_end,
  input wire hs_ack_stb,
  output reg hs_stb,
  output reg [1:0] hs_code,
  output wire irq
);

  localparam ST_IDLE = 3'd0;
  localparam ST_RX = 3'd1;
  localparam ST_TX_FETCH = 3'd2;
  localparam ST_TX_SEND = 3'd3;
  localparam ST_ACK_WAIT = 3'd4;

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  reg [7:0] usb_ctrl_r;
  reg [7:0] phy_r;
  reg [7:0] mode14_r;
  reg [7:0] mode23_r;
  reg [7:0] buf_lo_r [0:3];
  reg [1:0] buf_hi_r [0:3];
  reg [2:0] flag_r;
  reg [7:0] stat_r;
  reg [7:0] rx_len_r;
  wire sie_clr;
  wire [39:0] ep_ctl_w;
  wire [39:0] ep_len_w;
  wire [4:0] ep_rx_done;
  wire [4:0] ep_tx_done;
  integer k;

  assign sie_clr = usb_ctrl_r[`UEP_USB_SOFT_RST];

  // Pin controls follow the port control bits and the USB control pull-up enable bit directly
  assign device_enable = usb_ctrl_r[`UEP_USB_PULLUP];
  assign pullup_dp_en = usb_ctrl_r[`UEP_USB_PULLUP] & ~phy_r[`UEP_PHY_LOW_SPD];
  assign pullup_dm_en = usb_ctrl_r[`UEP_USB_PULLUP] & phy_r[`UEP_PHY_LOW_SPD];
  assign pulldown_en = ~phy_r[`UEP_PHY_PD_DIS];
  assign phy_low_speed = phy_r[`UEP_PHY_LOW_SPD];
  assign phy_enable = phy_r[`UEP_PHY_PORT_EN];
  assign irq = |flag_r;

  // Protocol engine soft reset bit only answers to the chip reset
  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      usb_ctrl_r <= `UEP_USB_CTRL_RST;
    else if (sfr_wr && sfr_addr == `UEP_USB_CTRL_OFF)
      usb_ctrl_r <= {2'b00, sfr_wdata[5], 2'b00, sfr_wdata[2], 2'b00};
  end

  // Port, mode and buffer start registers; soft reset restores port and mode only
  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      phy_r <= `UEP_PHY_CTRL_RST;
      mode14_r <= `UEP_MODE_RST;
      mode23_r <= `UEP_MODE_RST;
      for (k = 0; k < 4; k = k + 1)
      begin
        buf_lo_r[k] <= 8'h00;
        buf_hi_r[k] <= 2'b00;
      end
    end
    else if (sie_clr)
    begin
      phy_r <= `UEP_PHY_CTRL_RST;
      mode14_r <= `UEP_MODE_RST;
      mode23_r <= `UEP_MODE_RST;
    end
    else if (sfr_wr)
    begin
      if (sfr_addr == `UEP_PHY_CTRL_OFF)
        phy_r <= {sfr_wdata[7], 4'h0, sfr_wdata[2:0]};
      else if (sfr_addr == `UEP_MODE14_OFF)
        mode14_r <= {sfr_wdata[7:6], 1'b0, sfr_wdata[4:2], 2'b00};
      else if (sfr_addr == `UEP_MODE23_OFF)
        mode23_r <= {sfr_wdata[7:6], 1'b0, sfr_wdata[4], sfr_wdata[3:2], 1'b0, sfr_wdata[0]};
      else if (sfr_addr == `UEP_EP0_BUF_LO_OFF)
        buf_lo_r[0] <= sfr_wdata;
      else if (sfr_addr == `UEP_EP0_BUF_HI_OFF)
        buf_hi_r[0] <= sfr_wdata[1:0];
      else if (sfr_addr == `UEP_EP1_BUF_LO_OFF)
        buf_lo_r[1] <= sfr_wdata;
      else if (sfr_addr == `UEP_EP1_BUF_HI_OFF)
        buf_hi_r[1] <= sfr_wdata[1:0];
      else if (sfr_addr == `UEP_EP2_BUF_LO_OFF)
        buf_lo_r[2] <= sfr_wdata;
      else if (sfr_addr == `UEP_EP2_BUF_HI_OFF)
        buf_hi_r[2] <= sfr_wdata[1:0];
      else if (sfr_addr == `UEP_EP3_BUF_LO_OFF)
        buf_lo_r[3] <= sfr_wdata;
      else if (sfr_addr == `UEP_EP3_BUF_HI_OFF)
        buf_hi_r[3] <= sfr_wdata[1:0];
    end
  end

  // ----------------------------------------------------------------
  // Per-endpoint control and length registers
  // ----------------------------------------------------------------
  function [7:0] ctl_off;
    input integer i;
    begin
      case (i)
        0: ctl_off = `UEP_EP0_CTRL_OFF;
        1: ctl_off = `UEP_EP1_CTRL_OFF;
        2: ctl_off = `UEP_EP2_CTRL_OFF;
        3: ctl_off = `UEP_EP3_CTRL_OFF;
        default: ctl_off = `UEP_EP4_CTRL_OFF;
      endcase
    end
  endfunction

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1)
    begin : g_ep
      uep_ep_ctl #(.HAS_AUTO((gi >= 1 && gi <= 3) ? 1 : 0)) u_ep (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .sie_clr(sie_clr),
        .wr_ctl(sfr_wr && sfr_addr == ctl_off(gi)),
        .wr_len(sfr_wr && sfr_addr == ctl_off(gi) + 8'h01),
        .wdata(sfr_wdata),
        .rx_done(ep_rx_done[gi]),
        .tx_done(ep_tx_done[gi]),
        .ctl_q(ep_ctl_w[8*gi+:8]),
        .len_q(ep_len_w[8*gi+:8])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Endpoint direction enables and buffer placement
  // ----------------------------------------------------------------
  wire [4:0] rx_en;
  wire [4:0] tx_en;
  wire [4:0] dbl;
  assign rx_en = {mode14_r[3], mode23_r[7], mode23_r[3], mode14_r[7], 1'b1};
  assign tx_en = {mode14_r[2], mode23_r[6], mode23_r[2], mode14_r[6], 1'b1};
  assign dbl = {1'b0, mode23_r[4], mode23_r[0], mode14_r[4], 1'b0};

  reg [2:0] sel_ep;
  reg [1:0] sel_buf;
  reg [7:0] sel_ctl;
  reg [`UEP_RAM_AW-1:0] sel_start;
  reg [`UEP_RAM_AW-1:0] rx_base;
  reg [`UEP_RAM_AW-1:0] tx_base;
  reg tok_ok;

  // Token decode; endpoints 0 and 4 share start register 0
  always @*
  begin
    sel_ep = tok_ep[2:0];
    sel_buf = (tok_ep[2:0] == 3'd4) ? 2'd0 : tok_ep[1:0];
    sel_ctl = ep_ctl_w[8*sel_ep+:8];
    sel_start = {buf_hi_r[sel_buf], buf_lo_r[sel_buf]};
    tok_ok = (tok_ep <= 4'd4) && phy_r[`UEP_PHY_PORT_EN] && usb_ctrl_r[`UEP_USB_PULLUP];
    rx_base = sel_start;
    tx_base = sel_start;
    if (sel_ep == 3'd4)
    begin
      rx_base = sel_start + 10'd64;
      tx_base = sel_start + (rx_en[4] ? 10'd128 : 10'd64);
    end
    else if (sel_ep != 3'd0)
    begin
      rx_base = sel_start + ((dbl[sel_ep] & sel_ctl[`UEP_CTL_RX_TOG]) ? 10'd64 : 10'd0);
      tx_base = sel_start + (rx_en[sel_ep] ? (dbl[sel_ep] ? 10'd128 : 10'd64) : 10'd0)
        + ((dbl[sel_ep] & sel_ctl[`UEP_CTL_TX_TOG]) ? 10'd64 : 10'd0);
    end
  end

  // ----------------------------------------------------------------
  // Transaction engine
  // ----------------------------------------------------------------
  reg [2:0] st_r;
  reg [2:0] cur_ep_r;
  reg [1:0] cur_pid_r;
  reg [1:0] cur_res_r;
  reg cur_tog_r;
  reg rx_tog_r;
  reg ovf_r;
  reg [6:0] cnt_r;
  reg [6:0] len_r;
  reg [`UEP_RAM_AW-1:0] addr_r;
  reg [4:0] rx_done_r;
  reg [4:0] tx_done_r;
  reg xfer_set;
  wire ram_we;
  wire [7:0] ram_rdata;
  wire [7:0] tok_len;

  assign tok_len = ep_len_w[8*sel_ep+:8];
  assign ram_we = (st_r == ST_RX) && rx_stb && (cnt_r < `UEP_MAX_PKT) && !cur_res_r[1];
  assign tx_valid = (st_r == ST_TX_SEND);
  assign tx_byte = ram_rdata;
  assign ep_rx_done = rx_done_r;
  assign ep_tx_done = tx_done_r;

  // Buffer bytes move in ascending order from the start address
  uep_ram u_ram (
    .core_clk(core_clk),
    .eng_addr(addr_r + {3'b000, cnt_r}),
    .eng_we(ram_we),
    .eng_wdata(rx_byte),
    .eng_rdata(ram_rdata),
    .cpu_addr(xram_addr),
    .cpu_we(xram_we),
    .cpu_wdata(xram_wdata),
    .cpu_rdata(xram_rdata)
  );

  // Token, data and handshake sequencing
  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_r <= ST_IDLE;
      cur_ep_r <= 3'd0;
      cur_pid_r <= 2'b00;
      cur_res_r <= 2'b00;
      cur_tog_r <= 1'b0;
      rx_tog_r <= 1'b0;
      ovf_r <= 1'b0;
      cnt_r <= 7'd0;
      len_r <= 7'd0;
      addr_r <= 10'd0;
      tx_start <= 1'b0;
      tx_data1 <= 1'b0;
      tx_end <= 1'b0;
      hs_stb <= 1'b0;
      hs_code <= 2'b00;
      rx_done_r <= 5'd0;
      tx_done_r <= 5'd0;
      xfer_set <= 1'b0;
      stat_r <= 8'h00;
      rx_len_r <= 8'h00;
    end
    else
    begin
      tx_start <= 1'b0;
      tx_end <= 1'b0;
      hs_stb <= 1'b0;
      rx_done_r <= 5'd0;
      tx_done_r <= 5'd0;
      xfer_set <= 1'b0;
      if (sie_clr || xfer_abort)
        st_r <= ST_IDLE;
      else
      case (st_r)
        ST_IDLE:
          if (tok_stb && tok_ok)
          begin
            cur_ep_r <= sel_ep;
            cur_pid_r <= tok_pid;
            cur_tog_r <= sel_ctl[`UEP_CTL_RX_TOG];
            cnt_r <= 7'd0;
            ovf_r <= 1'b0;
            if ((tok_pid == `UEP_PID_OUT || tok_pid == `UEP_PID_SETUP) && rx_en[sel_ep])
            begin
              cur_res_r <= sel_ctl[3:2];
              addr_r <= rx_base;
              st_r <= ST_RX;
            end
            else if (tok_pid == `UEP_PID_IN && tx_en[sel_ep])
            begin
              cur_res_r <= sel_ctl[1:0];
              if (sel_ctl[1])
              begin
                hs_stb <= 1'b1;
                hs_code <= sel_ctl[1:0];
              end
              else
              begin
                addr_r <= tx_base;
                len_r <= (tok_len > 8'd64) ? `UEP_MAX_PKT : tok_len[6:0];
                tx_start <= 1'b1;
                tx_data1 <= sel_ctl[`UEP_CTL_TX_TOG];
                st_r <= ST_TX_FETCH;
              end
            end
          end
        ST_RX:
          if (rx_pid_stb)
            rx_tog_r <= rx_pid_data1;
          else if (rx_stb)
          begin
            if (cnt_r < `UEP_MAX_PKT)
              cnt_r <= cnt_r + 7'd1;
            else
              ovf_r <= 1'b1;
          end
          else if (rx_end)
          begin
            st_r <= ST_IDLE;
            if (!rx_err && !ovf_r)
            begin
              hs_stb <= (cur_res_r != `UEP_RES_NONE);
              hs_code <= cur_res_r;
              if (!cur_res_r[1])
              begin
                xfer_set <= 1'b1;
                rx_len_r <= {1'b0, cnt_r};
                stat_r <= {1'b0, rx_tog_r == cur_tog_r, cur_pid_r, 1'b0, cur_ep_r};
                rx_done_r[cur_ep_r] <= (rx_tog_r == cur_tog_r);
              end
            end
          end
        ST_TX_FETCH:
          if (cnt_r == len_r)
          begin
            tx_end <= 1'b1;
            if (cur_res_r == `UEP_RES_NONE)
            begin
              st_r <= ST_IDLE;
              xfer_set <= 1'b1;
              stat_r <= {2'b00, cur_pid_r, 1'b0, cur_ep_r};
              tx_done_r[cur_ep_r] <= 1'b1;
            end
            else
              st_r <= ST_ACK_WAIT;
          end
          else
            st_r <= ST_TX_SEND;
        ST_TX_SEND:
          if (tx_ready)
          begin
            cnt_r <= cnt_r + 7'd1;
            st_r <= ST_TX_FETCH;
          end
        ST_ACK_WAIT:
          if (hs_ack_stb)
          begin
            st_r <= ST_IDLE;
            xfer_set <= 1'b1;
            stat_r <= {2'b00, cur_pid_r, 1'b0, cur_ep_r};
            tx_done_r[cur_ep_r] <= 1'b1;
          end
        default:
          st_r <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Event flags: write one to clear, a new event wins over the clear
  // ----------------------------------------------------------------
  wire [2:0] flag_clr;
  wire [2:0] flag_set;
  assign flag_clr = (sfr_wr && sfr_addr == `UEP_EVT_FLAG_OFF) ? sfr_wdata[2:0] : 3'b000;
  assign flag_set = {suspend_det, xfer_set, bus_reset_det};

  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      flag_r <= 3'b000;
    else if (sie_clr)
      flag_r <= 3'b000;
    else
      flag_r <= (flag_r & ~flag_clr) | flag_set;
  end

  // ----------------------------------------------------------------
  // Register read port; unmapped offsets read zero
  // ----------------------------------------------------------------
  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      sfr_rdata <= 8'h00;
    else if (sfr_rd)
    begin
      if (sfr_addr == `UEP_PHY_CTRL_OFF)
        sfr_rdata <= {phy_r[7:6], dplus_in, dminus_in, phy_r[3:0]};
      else if (sfr_addr == `UEP_USB_CTRL_OFF)
        sfr_rdata <= usb_ctrl_r;
      else if (sfr_addr == `UEP_EP0_CTRL_OFF)
        sfr_rdata <= ep_ctl_w[7:0];
      else if (sfr_addr == `UEP_EP0_TLEN_OFF)
        sfr_rdata <= ep_len_w[7:0];
      else if (sfr_addr == `UEP_EP1_CTRL_OFF)
        sfr_rdata <= ep_ctl_w[15:8];
      else if (sfr_addr == `UEP_EP1_TLEN_OFF)
        sfr_rdata <= ep_len_w[15:8];
      else if (sfr_addr == `UEP_EP2_CTRL_OFF)
        sfr_rdata <= ep_ctl_w[23:16];
      else if (sfr_addr == `UEP_EP2_TLEN_OFF)
        sfr_rdata <= ep_len_w[23:16];
      else if (sfr_addr == `UEP_EP3_CTRL_OFF)
        sfr_rdata <= ep_ctl_w[31:24];
      else if (sfr_addr == `UEP_EP3_TLEN_OFF)
        sfr_rdata <= ep_len_w[31:24];
      else if (sfr_addr == `UEP_EP4_CTRL_OFF)
        sfr_rdata <= ep_ctl_w[39:32];
      else if (sfr_addr == `UEP_EP4_TLEN_OFF)
        sfr_rdata <= ep_len_w[39:32];
      else if (sfr_addr == `UEP_MODE14_OFF)
        sfr_rdata <= mode14_r;
      else if (sfr_addr == `UEP_MODE23_OFF)
        sfr_rdata <= mode23_r;
      else if (sfr_addr == `UEP_EP0_BUF_LO_OFF)
        sfr_rdata <= buf_lo_r[0];
      else if (sfr_addr == `UEP_EP0_BUF_HI_OFF)
        sfr_rdata <= {6'h00, buf_hi_r[0]};
      else if (sfr_addr == `UEP_EP1_BUF_LO_OFF)
        sfr_rdata <= buf_lo_r[1];
      else if (sfr_addr == `UEP_EP1_BUF_HI_OFF)
        sfr_rdata <= {6'h00, buf_hi_r[1]};
      else if (sfr_addr == `UEP_EP2_BUF_LO_OFF)
        sfr_rdata <= buf_lo_r[2];
      else if (sfr_addr == `UEP_EP2_BUF_HI_OFF)
        sfr_rdata <= {6'h00, buf_hi_r[2]};
      else if (sfr_addr == `UEP_EP3_BUF_LO_OFF)
        sfr_rdata <= buf_lo_r[3];
      else if (sfr_addr == `UEP_EP3_BUF_HI_OFF)
        sfr_rdata <= {6'h00, buf_hi_r[3]};
      else if (sfr_addr == `UEP_EVT_FLAG_OFF)
        sfr_rdata <= {1'b0, stat_r[`UEP_STAT_TOG_OK], 3'b000, flag_r};
      else if (sfr_addr == `UEP_EVT_STAT_OFF)
        sfr_rdata <= stat_r;
      else if (sfr_addr == `UEP_RX_LEN_OFF)
        sfr_rdata <= rx_len_r;
      else
        sfr_rdata <= 8'h00;
    end
  end

endmodule

// File: dv/uep_top_sva.sv
`timescale 1ns/100ps
// ----
// Port checker
// ----
module uep_top_sva
(
  input wire core_clk,
  input wire rst_b,
  input wire [7:0] sfr_addr,
  input wire sfr_rd,
  input wire [7:0] sfr_rdata,
  input wire dplus_in,
  input wire dminus_in,
  input wire pullup_dp_en,
  input wire pullup_dm_en,
  input wire pulldown_en,
  input wire phy_enable,
  input wire phy_low_speed,
  input wire device_enable,
  input wire tok_stb,
  input wire rx_stb,
  input wire rx_end,
  input wire tx_valid,
  input wire tx_ready,
  input wire [7:0] tx_byte,
  input wire hs_stb,
  input wire [1:0] hs_code
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  wire phy_rd = sfr_rd && sfr_addr == 8'hd1;
  reg [7:0] cnt_r;
  // Bytes since the token; saturates so a runaway packet stays overlong
  always @(posedge core_clk or negedge rst_b)
    if (!rst_b)
      cnt_r <= 8'h00;
    else if (tok_stb)
      cnt_r <= 8'h00;
    else if (rx_stb && cnt_r != 8'hff)
      cnt_r <= cnt_r + 8'h01;
  AST_PULLUP: assert property ({pullup_dp_en, pullup_dm_en} ==
    {device_enable & !phy_low_speed, device_enable & phy_low_speed}) else $error("pullup");
  AST_PIN_LVL: assert property (phy_rd |=>
    sfr_rdata[5:4] == {$past(dplus_in), $past(dminus_in)}) else $error("pins");
  AST_PD_DIS: assert property (phy_rd |=> sfr_rdata[7] == !$past(pulldown_en)) else $error("pd");
  AST_SPD_EN: assert property (phy_rd |=>
    {sfr_rdata[2], sfr_rdata[0]} == {$past(phy_low_speed), $past(phy_enable)}) else $error("spd");
  AST_RSVD: assert property (phy_rd |=> (sfr_rdata & 8'h48) == 8'h00) else $error("rsvd");
  AST_HS_CODE: assert property (hs_stb |-> hs_code != 2'b01 ##1 !hs_stb) else $error("hs");
  AST_TX_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte)) else $error("tx");
  AST_OVERLONG: assert property (rx_end && cnt_r > 8'h40 |=> !hs_stb [*2]) else $error("long");
endmodule
bind uep_top uep_top_sva uep_top_sva_i (.*);

// File: dv/uep_host_model.sv
`timescale 1ns/100ps
// ----
// Host side of the link
// ----
module uep_host_model
(
  input wire core_clk,
  input wire tx_valid,
  input wire tx_end,
  output reg tx_ready = 1'b0,
  output reg hs_ack_stb = 1'b0
);
  reg end_r = 1'b0;
  // Slow host: ready drops for one edge after each accepted byte; ack comes two edges after the end
  always @(posedge core_clk)
  begin
    tx_ready <= !(tx_ready && tx_valid);
    end_r <= tx_end;
    hs_ack_stb <= end_r;
  end
endmodule

// File: dv/uep_top_tb.sv
`timescale 1ns/100ps
// ----
// Bench
// ----
module uep_top_tb;
  logic core_clk=0, rst_b=0, sfr_wr=0, sfr_rd=0, xram_we=0, bus_reset_det=0, suspend_det=0;
  logic tok_stb=0, rx_pid_stb=0, rx_pid_data1=0, rx_stb=0, rx_end=0, rx_err=0, xfer_abort=0, rdv=0;
  logic dplus_in, dminus_in, tx_ready, hs_ack_stb, tx_start, tx_data1, tx_valid, tx_end, hs_stb, irq;
  logic pullup_dp_en, pullup_dm_en, pulldown_en, phy_enable, phy_low_speed, device_enable;
  logic [7:0] sfr_addr=0, sfr_wdata=0, xram_wdata=0, rx_byte=0, sfr_rdata, xram_rdata, tx_byte, v;
  logic [9:0] xram_addr=0;
  logic [1:0] tok_pid=0, hs_code;
  logic [3:0] tok_ep=0;
  logic [7:0] eq_rd[$], eq_hs[$], eq_tx[$], eq_tg[$];
  byte cs[3] = '{3, 2, 0};
  int fail_count=0, samples_checked=0, seed=32'he00295ef;
  uep_top uep_top_i (.*);
  uep_host_model uep_host_model_i (.*);
  always #12.5 core_clk = !core_clk;
  initial #100000 begin fail_count++; close_out; end
  task tick; @(posedge core_clk); #2; endtask
  task chk(input string n, input logic [7:0] e, s);
    samples_checked++;
    if (s !== e) begin fail_count++; $display("[ERR] %s exp %h got %h", n, e, s); end
  endtask
  // A quiet edge after each strobe keeps back-to-back calls from re-raising it in one step
  task wr(input logic [7:0] a, d); sfr_addr=a; sfr_wdata=d; sfr_wr=1; tick; sfr_wr=0; tick; endtask
  task rd(input logic [7:0] a, e); sfr_addr=a; sfr_rd=1; eq_rd.push_back(e); tick; sfr_rd=0; tick; endtask
  task tok(input logic [1:0] p); tok_pid=p; tok_stb=1; tick; tok_stb=0; tick; endtask
  // Token, data PID, bytes back to back, end; kept bytes come back on IN
  task out(input int n, input logic keep, t);
    tok(2'b00); rx_pid_data1=t; rx_pid_stb=1; tick; rx_pid_stb=0;
    repeat (n) begin rx_byte=$random(seed); if (keep) eq_tx.push_back(rx_byte); rx_stb=1; tick; end
    rx_stb=0; rx_end=1; tick; rx_end=0; repeat (3) tick;
  endtask
  task close_out;
    if (fail_count == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Watcher: an unexpected result meets an unknown note and fails
  always @(posedge core_clk)
  begin
    rdv <= sfr_rd;
    if (rdv) chk("rd", eq_rd.size() ? eq_rd.pop_front() : 8'hxx, sfr_rdata);
    if (hs_stb) chk("hs", eq_hs.size() ? eq_hs.pop_front() : 8'hxx, {6'h0, hs_code});
    if (tx_valid && tx_ready) chk("tx", eq_tx.size() ? eq_tx.pop_front() : 8'hxx, tx_byte);
    if (tx_start) chk("tog", eq_tg.size() ? eq_tg.pop_front() : 8'hxx, {7'h0, tx_data1});
    if (tx_end) chk("left", 8'h00, eq_tx.size());
  end
  initial
  begin
    {dplus_in, dminus_in} = $random(seed);
    repeat (4) @(posedge core_clk);
    #2 rst_b = 1;
    rd(8'hd1, {2'b10, dplus_in, dminus_in, 4'h0});
    rd(8'hdc, 8'h00);
    wr(8'he2, 8'h20);
    v = $random(seed) & 8'h86 | 8'h01;
    wr(8'hd1, v);
    rd(8'hd1, v | {2'b0, dplus_in, dminus_in, 4'h0});
    wr(8'hdd, 8'h02);
    wr(8'hdc, 8'h10);
    rd(8'hdc, 8'h00);
    wr(8'hef, 8'hfe);
    rd(8'hef, 8'h02);
    foreach (cs[i])
    begin
      wr(8'hd8, 8'h07);
      wr(8'hdc, {1'b0, cs[i] == 0, 2'h0, cs[i][1:0], cs[i][1:0]});
      eq_hs.push_back(cs[i]);
      out(2, cs[i] == 0, cs[i][0]);
      if (cs[i] == 0)
      begin
        rd(8'hdb, 8'h02);
        rd(8'hd9, 8'h40);
        {suspend_det, bus_reset_det} = 2'b11;
        tick;
        {suspend_det, bus_reset_det} = 2'b00;
        rd(8'hd8, 8'h47);
        chk("irq", 8'h01, {7'h0, irq});
        xram_addr = 1;
        repeat (2) tick;
        chk("ram", eq_tx[1], xram_rdata);
        eq_tg.push_back(8'h01);
      end
      else eq_hs.push_back(cs[i]);
      tok(2'b10);
      repeat (20) tick;
    end
    tok_ep = 4'h5;
    tok(2'b10);
    tok_ep = 4'h0;
    out(65, 0, 0);
    rd(8'hdb, 8'h02);
    close_out;
  end
endmodule
